// ---- design/pnpp_port.v ----
// parallel high-voltage programming port, device side
// Contract
// (RQ1) command byte picks erase, flash, eeprom, fuse or lock write
// (RQ2) read commands: signature, fuse/lock, flash and eeprom codes; the read path never decodes the signature code 08, so data_oe stays low for it
// (RQ3) programmer holds entry pins stable 10us after high voltage applied
// (RQ4) programmer waits 300us after entry before any command
// (RQ5) programming mode ends on power down or reset pin at 0V
// (RQ6) last command and address kept across operations
// (RQ7) address high byte stays until reloaded for a new window
// (RQ8) chip erase clears flash, eeprom, locks; keeps fuses; preserve fuse keeps eeprom
// (RQ9) lock bits cleared only after flash erase finishes
// (RQ10) write strobe after erase command starts erase; busy until done
// (RQ11) action select on load strobe: 10 command, 00 address, 01 data
// (RQ12) byte select 0 loads address low, 1 loads address high
// (RQ13) byte select 0 loads data low, 1 loads data high
// (RQ14) page latch with byte select high stores data word in buffer
// (RQ15) low address bits pick word, upper bits pick page
// (RQ16) write strobe after address high programs flash page, busy until done
// (RQ17) loading command 0000 0000 resets internal write state
// (RQ18) eeprom page buffered; write strobe with byte select low programs it
// (RQ19) flash read drives low or high byte by byte select
// (RQ20) eeprom read with byte select 0 drives eeprom byte
// (RQ21) low fuse write takes data low byte, committed by write strobe
// (RQ22) programmer erases chip before reprogramming flash or eeprom
// (RQ23) ready/busy is 0 while busy, 1 when ready
// (RQ24) data bus driven only while output enable low
// (RQ25) while busy, write strobes and command loads are ignored
`timescale 1ns/1ns
`include "pnpp_defs.vh"
module pnpp_port #(
    parameter PAGE_AW = 7,
    parameter EEP_AW  = 3
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // programmer pins
    input  wire        hv_reset_level,
    input  wire        load_strobe,
    input  wire        action_select_hi,
    input  wire        action_select_lo,
    input  wire        byte_select_a,
    input  wire        byte_select_b,
    input  wire        page_latch_strobe,
    input  wire        write_strobe_n,
    input  wire        output_enable_n,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output wire        data_oe,
    output wire        ready_busy_flag,
    // fuse levels
    input  wire        eeprom_preserve_fuse,
    input  wire [7:0]  fuse_lo_init,
    // memory engine requests
    output reg         nvm_req,
    output reg  [2:0]  nvm_op,
    output reg  [15:0] nvm_addr,
    output reg  [7:0]  nvm_wdata,
    input  wire        nvm_done,
    input  wire [PAGE_AW-1:0] nvm_buf_addr,
    output wire [15:0] nvm_buf_data,
    // memory read data
    input  wire [15:0] flash_rd_data,
    input  wire [7:0]  eep_rd_data,
    // state
    output wire        prog_mode,
    output wire [7:0]  lock_bits,
    output wire [7:0]  fuse_lo
);

    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_ER_F = 2'h2;
    localparam ST_ER_E = 2'h3;
    localparam NPIN    = 16;

    // two-flop synchronisers per pin bit
    wire [NPIN-1:0] pin_raw = {data_in, hv_reset_level, load_strobe, action_select_hi, action_select_lo,
                               byte_select_a, byte_select_b, page_latch_strobe, output_enable_n};
    reg  [NPIN-1:0] meta_q;
    reg  [NPIN-1:0] sync_q;
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    reg wr_meta_q;
    reg wr_sync_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_meta_q <= 1'b1;
            wr_sync_q <= 1'b1;
        end else begin
            wr_meta_q <= write_strobe_n;
            wr_sync_q <= wr_meta_q;
        end
    end

    wire [7:0] din_s  = sync_q[15:8];
    wire       hv_s   = sync_q[7];
    wire       ld_s   = sync_q[6];
    wire [1:0] act_s  = sync_q[5:4];
    wire       bsa_s  = sync_q[3];
    wire       bsb_s  = sync_q[2];
    wire       pgl_s  = sync_q[1];
    wire       oen_s  = sync_q[0];

    // strobe edge detection
    reg ld_prev_q;
    reg pgl_prev_q;
    reg wr_prev_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ld_prev_q  <= 1'b0;
            pgl_prev_q <= 1'b0;
            wr_prev_q  <= 1'b1;
        end else begin
            ld_prev_q  <= ld_s;
            pgl_prev_q <= pgl_s;
            wr_prev_q  <= wr_sync_q;
        end
    end
    wire ld_rise  = ld_s & ~ld_prev_q;
    wire pgl_rise = pgl_s & ~pgl_prev_q;
    wire wr_fall  = ~wr_sync_q & wr_prev_q;

    // entry pattern checked after hold time
    reg        mode_q;
    reg        entry_arm_q;
    reg [15:0] entry_cnt_q;
    wire       pattern_ok = ~pgl_s & (act_s == 2'h0) & ~bsa_s;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q      <= 1'b0;
            entry_arm_q <= 1'b0;
            entry_cnt_q <= 16'h0000;
        end else if (!hv_s) begin
            mode_q      <= 1'b0;                                   // [RQ5]
            entry_arm_q <= 1'b1;
            entry_cnt_q <= 16'h0000;
        end else if (entry_arm_q) begin
            if (entry_cnt_q == `PNPP_ENTRY_CYCLES - 1) begin       // [RQ3]
                entry_arm_q <= 1'b0;
                mode_q      <= pattern_ok;
            end else begin
                entry_cnt_q <= entry_cnt_q + 16'h0001;
            end
        end
    end
    assign prog_mode = mode_q;

    // loaded command, address and data
    reg [7:0]  cmd_q;
    reg [7:0]  addr_lo_q;
    reg [7:0]  addr_hi_q;
    reg [7:0]  dat_lo_q;
    reg [7:0]  dat_hi_q;
    reg [1:0]  state_q;
    reg [7:0]  lock_q;
    reg [7:0]  fuse_q;
    reg        fuse_cap_q;
    wire       busy = (state_q != ST_IDLE);
    wire       load_ev = mode_q & ld_rise;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_q     <= `PNPP_CMD_NOP;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            dat_lo_q  <= 8'h00;
            dat_hi_q  <= 8'h00;
        end else if (!mode_q) begin
            cmd_q     <= `PNPP_CMD_NOP;
        end else if (load_ev) begin
            case (act_s)                                           // [RQ11]
                `PNPP_ACT_CMD: begin
                    if (!busy) begin
                        cmd_q <= din_s;                            // [RQ25] [RQ6]
                    end
                end
                `PNPP_ACT_ADDR: begin
                    if (bsa_s) begin
                        addr_hi_q <= din_s;                        // [RQ12] [RQ7]
                    end else begin
                        addr_lo_q <= din_s;                        // [RQ12]
                    end
                end
                `PNPP_ACT_DATA: begin
                    if (bsa_s) begin
                        dat_hi_q <= din_s;                         // [RQ13]
                    end else begin
                        dat_lo_q <= din_s;                         // [RQ13]
                    end
                end
                default: begin
                    dat_lo_q <= dat_lo_q;
                end
            endcase
        end
    end

    // page buffer fill
    reg        buf_dirty_q;
    wire       is_flash_wr = (cmd_q == `PNPP_CMD_WR_FLASH);
    wire       is_eep_wr   = (cmd_q == `PNPP_CMD_WR_EEP);
    wire       latch_flash = mode_q & pgl_rise & bsa_s & is_flash_wr;   // [RQ14]
    wire       latch_eep   = mode_q & pgl_rise & is_eep_wr;             // [RQ18]
    wire       buf_we      = (latch_flash | latch_eep) & ~busy;
    wire [PAGE_AW-1:0] buf_widx = is_eep_wr ? {{(PAGE_AW-EEP_AW){1'b0}}, addr_lo_q[EEP_AW-1:0]}
                                            : addr_lo_q[PAGE_AW-1:0];   // [RQ15]

    pnpp_page_ram #(
        .AW (PAGE_AW),
        .DW (16)
    ) u_buf (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wr_en   (buf_we),
        .wr_addr (buf_widx),
        .wr_data ({dat_hi_q, dat_lo_q}),
        .rd_addr (nvm_buf_addr),
        .rd_data (nvm_buf_data)
    );

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            buf_dirty_q <= 1'b0;
        end else if (buf_we) begin
            buf_dirty_q <= 1'b1;
        end else if (load_ev && act_s == `PNPP_ACT_CMD && !busy && din_s == `PNPP_CMD_NOP) begin
            buf_dirty_q <= 1'b0;                                   // [RQ17]
        end
    end

    // write strobe dispatch
    wire        wr_ev     = mode_q & wr_fall & ~busy;                   // [RQ25]
    wire [15:0] flash_pg  = {addr_hi_q, addr_lo_q[7:PAGE_AW], {PAGE_AW{1'b0}}};     // [RQ15]
    wire [15:0] eep_pg    = {addr_hi_q, addr_lo_q[7:EEP_AW], {EEP_AW{1'b0}}};
    wire        keep_eep  = ~eeprom_preserve_fuse;                      // programmed reads 0
    reg  [1:0]  state_d;
    reg         req_d;
    reg  [2:0]  op_d;
    reg  [15:0] addr_d;
    reg  [7:0]  wdata_d;

    always @* begin
        state_d = state_q;
        req_d   = 1'b0;
        op_d    = nvm_op;
        addr_d  = nvm_addr;
        wdata_d = nvm_wdata;
        case (state_q)
            ST_IDLE: begin
                if (wr_ev) begin
                    case (cmd_q)                                   // [RQ1]
                        `PNPP_CMD_ERASE: begin
                            state_d = ST_ER_F;                     // [RQ10] [RQ8]
                            req_d   = 1'b1;
                            op_d    = `PNPP_OP_ERASE_FLASH;
                            addr_d  = 16'h0000;
                        end
                        `PNPP_CMD_WR_FLASH: begin
                            if (buf_dirty_q) begin
                                state_d = ST_RUN;                  // [RQ16]
                                req_d   = 1'b1;
                                op_d    = `PNPP_OP_FLASH_PAGE;
                                addr_d  = flash_pg;
                            end
                        end
                        `PNPP_CMD_WR_EEP: begin
                            if (!bsa_s && buf_dirty_q) begin
                                state_d = ST_RUN;                  // [RQ18]
                                req_d   = 1'b1;
                                op_d    = `PNPP_OP_EEP_PAGE;
                                addr_d  = eep_pg;
                            end
                        end
                        `PNPP_CMD_WR_FUSE: begin
                            if (!bsa_s && !bsb_s) begin
                                state_d = ST_RUN;                  // [RQ21]
                                req_d   = 1'b1;
                                op_d    = `PNPP_OP_FUSE_LO;
                                wdata_d = dat_lo_q;
                            end
                        end
                        `PNPP_CMD_WR_LOCK: begin
                            state_d = ST_RUN;
                            req_d   = 1'b1;
                            op_d    = `PNPP_OP_LOCK;
                            wdata_d = dat_lo_q & lock_q;
                        end
                        default: begin
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_RUN: begin
                if (nvm_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_ER_F: begin
                if (nvm_done) begin
                    if (keep_eep) begin
                        state_d = ST_IDLE;                         // [RQ8]
                    end else begin
                        state_d = ST_ER_E;
                        req_d   = 1'b1;
                        op_d    = `PNPP_OP_ERASE_EEP;
                    end
                end
            end
            ST_ER_E: begin
                if (nvm_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (!mode_q) begin
            state_d = ST_IDLE;
            req_d   = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= ST_IDLE;
            nvm_req   <= 1'b0;
            nvm_op    <= 3'h0;
            nvm_addr  <= 16'h0000;
            nvm_wdata <= 8'h00;
        end else begin
            state_q   <= state_d;
            nvm_req   <= req_d;
            nvm_op    <= op_d;
            nvm_addr  <= addr_d;
            nvm_wdata <= wdata_d;
        end
    end

    // lock and fuse shadows; fuses caught at entry
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lock_q     <= `PNPP_LOCK_RST;
            fuse_q     <= `PNPP_FUSE_RST;
            fuse_cap_q <= 1'b0;
        end else begin
            if (!mode_q) begin
                fuse_cap_q <= 1'b0;
            end else if (!fuse_cap_q) begin
                fuse_cap_q <= 1'b1;
                fuse_q     <= fuse_lo_init;
            end
            if (state_q == ST_ER_F && nvm_done) begin
                lock_q <= `PNPP_LOCK_RST;                          // [RQ9] [RQ8]
            end else if (state_q == ST_RUN && nvm_done && nvm_op == `PNPP_OP_LOCK) begin
                lock_q <= nvm_wdata;
            end
            if (state_q == ST_RUN && nvm_done && nvm_op == `PNPP_OP_FUSE_LO) begin
                fuse_q <= nvm_wdata;                               // [RQ21]
            end
        end
    end
    assign lock_bits = lock_q;
    assign fuse_lo   = fuse_q;

    assign ready_busy_flag = ~busy;                                // [RQ23]

    // read path
    wire is_rd = (cmd_q == `PNPP_CMD_RD_FLASH) | (cmd_q == `PNPP_CMD_RD_EEP) |
                 (cmd_q == `PNPP_CMD_RD_FUSE);                      // [RQ2]
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= 8'h00;
        end else begin
            case (cmd_q)
                `PNPP_CMD_RD_FLASH: data_out <= bsa_s ? flash_rd_data[15:8] : flash_rd_data[7:0];  // [RQ19]
                `PNPP_CMD_RD_EEP:   data_out <= eep_rd_data;                                       // [RQ20]
                `PNPP_CMD_RD_FUSE:  data_out <= bsa_s ? lock_q : fuse_q;
                default:            data_out <= 8'h00;
            endcase
        end
    end
    assign data_oe = mode_q & ~oen_s & ~busy & is_rd &
                     ~((cmd_q == `PNPP_CMD_RD_EEP) & bsa_s);       // [RQ24] [RQ20]

endmodule // pnpp_port

// ---- design/pnpp_defs.vh ----
// constants for the parallel programming port
`ifndef PNPP_DEFS_VH
`define PNPP_DEFS_VH

// command bytes
`define PNPP_CMD_NOP        8'h00
`define PNPP_CMD_ERASE      8'h80
`define PNPP_CMD_WR_FUSE    8'h40
`define PNPP_CMD_WR_LOCK    8'h20
`define PNPP_CMD_WR_FLASH   8'h10
`define PNPP_CMD_WR_EEP     8'h11
`define PNPP_CMD_RD_SIG     8'h08
`define PNPP_CMD_RD_FUSE    8'h04
`define PNPP_CMD_RD_FLASH   8'h02
`define PNPP_CMD_RD_EEP     8'h03

// action select codes {hi,lo}
`define PNPP_ACT_ADDR       2'h0
`define PNPP_ACT_DATA       2'h1
`define PNPP_ACT_CMD        2'h2

// memory engine op codes
`define PNPP_OP_ERASE_FLASH 3'h1
`define PNPP_OP_ERASE_EEP   3'h2
`define PNPP_OP_FLASH_PAGE  3'h3
`define PNPP_OP_EEP_PAGE    3'h4
`define PNPP_OP_FUSE_LO     3'h5
`define PNPP_OP_LOCK        3'h6

// reset values
`define PNPP_LOCK_RST       8'hFF
`define PNPP_FUSE_RST       8'hFF

// timing
`define PNPP_CLK_MHZ        10
`define PNPP_ENTRY_HOLD_US  10
`define PNPP_ENTRY_CYCLES   (`PNPP_ENTRY_HOLD_US * `PNPP_CLK_MHZ)

`endif

// ---- design/pnpp_page_ram.v ----
// page buffer memory with registered read port
`timescale 1ns/1ns
module pnpp_page_ram #(
    parameter AW = 7,
    parameter DW = 16
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          resetn,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // pnpp_page_ram

// ---- test/pnpp_port_chk.sv ----
// assertion checker for the programming port
`timescale 1ns/1ns
`include "pnpp_defs.vh"
module pnpp_port_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // programmer side
    input wire logic       hv_reset_level,
    input wire logic       output_enable_n,
    input wire logic       eeprom_preserve_fuse,
    input wire logic       data_oe,
    input wire logic       ready_busy_flag,
    // engine side and state
    input wire logic       nvm_req,
    input wire logic [2:0] nvm_op,
    input wire logic       nvm_done,
    input wire logic       prog_mode,
    input wire logic [7:0] lock_bits
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_req_shows_busy: assert property (nvm_req |-> !ready_busy_flag)
        else $error("ready high with request");
    a_ready_rise_cause: assert property ($rose(ready_busy_flag) |-> $past(nvm_done) || !prog_mode)
        else $error("ready rose without done");
    a_no_idle_req: assert property (!ready_busy_flag && !nvm_done |=> !nvm_req)
        else $error("request while busy");
    a_ready_after_done: assert property
        (nvm_done && !(nvm_op == `PNPP_OP_ERASE_FLASH && eeprom_preserve_fuse) |=> ready_busy_flag)
        else $error("ready late after done");
    a_eep_erase_chain: assert property (nvm_done && nvm_op == `PNPP_OP_ERASE_FLASH
        |=> ((nvm_req && nvm_op == `PNPP_OP_ERASE_EEP) == $past(eeprom_preserve_fuse)))
        else $error("eeprom erase step wrong");
    a_lock_held: assert property (nvm_op == `PNPP_OP_ERASE_FLASH && !ready_busy_flag && !nvm_done
        |=> $stable(lock_bits))
        else $error("locks changed in erase");
    a_lock_cleared: assert property (nvm_done && nvm_op == `PNPP_OP_ERASE_FLASH
        |=> lock_bits == `PNPP_LOCK_RST)
        else $error("locks not cleared");
    a_oe_released: assert property (output_enable_n [*4] |-> !data_oe)
        else $error("bus driven with oe high");
    a_mode_exit: assert property (!hv_reset_level [*5] |-> !prog_mode)
        else $error("mode kept, reset pin low");

    c_flash_page: cover property (nvm_req && nvm_op == `PNPP_OP_FLASH_PAGE);
    c_eep_page: cover property (nvm_req && nvm_op == `PNPP_OP_EEP_PAGE);
    c_eep_erase: cover property (nvm_req && nvm_op == `PNPP_OP_ERASE_EEP);
endmodule // pnpp_port_chk

// ---- test/pnpp_nvm_model.sv ----
// memory engine and array model
`timescale 1ns/1ns
`include "pnpp_defs.vh"
module pnpp_nvm_model (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         resetn,
    // engine requests
    input wire logic         nvm_req,
    input wire logic [2:0]   nvm_op,
    input wire logic [15:0]  nvm_addr,
    input wire logic [15:0]  nvm_buf_data,
    output logic             nvm_done,
    output logic [6:0]       nvm_buf_addr,
    // array reads
    input wire logic         slow_mode,
    input wire logic [9:0]   rd_addr,
    output logic [15:0]      flash_rd_data,
    output logic [7:0]       eep_rd_data
);
    logic [15:0] fm [0:1023];
    logic [7:0]  em [0:1023];
    logic [2:0]  op;
    logic [9:0]  base;
    int          n;

    assign flash_rd_data = fm[rd_addr];
    assign eep_rd_data   = em[rd_addr];

    initial begin
        for (int k = 0; k < 1024; k++) begin
            fm[k] = 16'h0000;
            em[k] = 8'h00;
        end
    end

    // walk the page buffer, one word of read latency
    always begin
        @(posedge sys_clk);
        if (!resetn) {nvm_done, nvm_buf_addr} <= 8'h00;
        if (resetn && nvm_req) begin
            op = nvm_op;
            base = nvm_addr[9:0];
            n = (op == `PNPP_OP_FLASH_PAGE) ? 128 : (op == `PNPP_OP_EEP_PAGE) ? 8 : 0;
            for (int i = 0; i <= n; i++) begin
                nvm_buf_addr <= 7'(i);
                @(posedge sys_clk);
                if (i > 0 && op == `PNPP_OP_FLASH_PAGE) fm[base + 10'(i - 1)] = nvm_buf_data;
                if (i > 0 && op == `PNPP_OP_EEP_PAGE) em[base + 10'(i - 1)] = nvm_buf_data[7:0];
            end
            for (int k = 0; k < 1024; k++) begin
                if (op == `PNPP_OP_ERASE_FLASH) fm[k] = 16'hFFFF;
                if (op == `PNPP_OP_ERASE_EEP) em[k] = 8'hFF;
            end
            repeat (slow_mode ? 200 : 4) @(posedge sys_clk);
            nvm_done <= 1'b1;
            @(posedge sys_clk);
            nvm_done <= 1'b0;
        end
    end
endmodule // pnpp_nvm_model

// ---- test/pnpp_port_tb_top.sv ----
// testbench for the programming port
`timescale 1ns/1ns
`include "pnpp_defs.vh"
module pnpp_port_tb_top;
    typedef struct packed {logic [7:0] cmd; logic bsa; logic [9:0] ra; logic [7:0] exp;} pnpp_row_t;
    logic        sys_clk, resetn, hv_reset_level, load_strobe, action_select_hi, action_select_lo;
    logic        byte_select_a, page_latch_strobe, write_strobe_n, output_enable_n;
    logic        eeprom_preserve_fuse, data_oe, ready_busy_flag, nvm_req, nvm_done, prog_mode, slow_mode;
    logic [7:0]  data_in, data_out, lock_bits, fuse_lo, eep_rd_data, nvm_wdata, last;
    logic [2:0]  nvm_op;
    logic [15:0] nvm_addr, nvm_buf_data, flash_rd_data;
    logic [6:0]  nvm_buf_addr;
    logic [9:0]  rd_addr;
    int          err_total, n_tests, cycles, w;
    pnpp_row_t   rows [0:4];

    pnpp_port dut (.sys_clk(sys_clk), .resetn(resetn), .hv_reset_level(hv_reset_level),
        .load_strobe(load_strobe), .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
        .byte_select_a(byte_select_a), .byte_select_b(1'b0), .page_latch_strobe(page_latch_strobe),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
        .eeprom_preserve_fuse(eeprom_preserve_fuse), .fuse_lo_init(8'hFF), .nvm_req(nvm_req),
        .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_done(nvm_done),
        .nvm_buf_addr(nvm_buf_addr), .nvm_buf_data(nvm_buf_data), .flash_rd_data(flash_rd_data),
        .eep_rd_data(eep_rd_data), .prog_mode(prog_mode), .lock_bits(lock_bits), .fuse_lo(fuse_lo));

    pnpp_nvm_model u_nvm (.sys_clk(sys_clk), .resetn(resetn), .nvm_req(nvm_req), .nvm_op(nvm_op),
        .nvm_addr(nvm_addr), .nvm_buf_data(nvm_buf_data), .nvm_done(nvm_done), .nvm_buf_addr(nvm_buf_addr),
        .slow_mode(slow_mode), .rd_addr(rd_addr), .flash_rd_data(flash_rd_data), .eep_rd_data(eep_rd_data));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // load strobe, selectors set up around it
    task ld(input logic [1:0] act, input logic bsa, input logic [7:0] d);
        action_select_hi <= act[1];
        action_select_lo <= act[0];
        byte_select_a <= bsa;
        data_in <= d;
        cyc(2);
        load_strobe <= 1'b1;
        cyc(4);
        load_strobe <= 1'b0;
        cyc(4);
    endtask

    task latch;
        byte_select_a <= 1'b1;
        cyc(2);
        page_latch_strobe <= 1'b1;
        cyc(4);
        page_latch_strobe <= 1'b0;
        cyc(4);
    endtask

    // write pulse; go: an operation should start
    task wr(input logic bsa, input logic go);
        byte_select_a <= bsa;
        cyc(2);
        write_strobe_n <= 1'b0;
        cyc(4);
        write_strobe_n <= 1'b1;
        cyc(2);
        chk(16'(ready_busy_flag), 16'(!go));
        if (slow_mode) begin
            write_strobe_n <= 1'b0;
            cyc(4);
            write_strobe_n <= 1'b1;
            cyc(4);
        end
        w = 0;
        while (ready_busy_flag !== 1'b1 && w < 3000) begin
            cyc(1);
            w++;
        end
        chk(16'(ready_busy_flag), 16'h0001);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim;
        end
    end

    initial begin
        {resetn, hv_reset_level, load_strobe, action_select_hi, action_select_lo, byte_select_a} = 6'h00;
        {page_latch_strobe, slow_mode, eeprom_preserve_fuse} = 3'h0;
        {write_strobe_n, output_enable_n} = 2'h3;
        data_in = 8'h00;
        rd_addr = 10'h000;
        rows = '{'{8'h02, 1'b0, 10'h185, 8'hA5}, '{8'h02, 1'b1, 10'h185, 8'h3C},
                 '{8'h03, 1'b0, 10'h00B, 8'h5A}, '{8'h04, 1'b0, 10'h000, 8'hE2}, '{8'h04, 1'b1, 10'h000, 8'hFC}};
        cyc(20);
        resetn <= 1'b1;
        cyc(5);
        chk({lock_bits, fuse_lo}, 16'hFFFF);
        chk(16'(prog_mode), 16'h0000);
        hv_reset_level <= 1'b1;
        cyc(3000);
        chk(16'(prog_mode), 16'h0001);
        eeprom_preserve_fuse <= 1'b1;
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_ERASE);
        wr(1'b0, 1'b1);
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_WR_FLASH);
        ld(`PNPP_ACT_ADDR, 1'b0, 8'h85);
        ld(`PNPP_ACT_DATA, 1'b0, 8'hA5);
        ld(`PNPP_ACT_DATA, 1'b1, 8'h3C);
        latch;
        ld(`PNPP_ACT_ADDR, 1'b1, 8'h01);
        slow_mode <= 1'b1;
        wr(1'b1, 1'b1);
        slow_mode <= 1'b0;
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_WR_EEP);
        ld(`PNPP_ACT_ADDR, 1'b1, 8'h00);
        ld(`PNPP_ACT_ADDR, 1'b0, 8'h0B);
        ld(`PNPP_ACT_DATA, 1'b0, 8'h5A);
        latch;
        wr(1'b0, 1'b1);
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_WR_FUSE);
        ld(`PNPP_ACT_DATA, 1'b0, 8'hE2);
        wr(1'b0, 1'b1);
        chk(16'(fuse_lo), 16'h00E2);
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_WR_LOCK);
        ld(`PNPP_ACT_DATA, 1'b0, 8'hFC);
        wr(1'b0, 1'b1);
        chk(16'(lock_bits), 16'h00FC);
        last = 8'hFF;
        foreach (rows[r]) begin
            if (rows[r].cmd !== last) ld(`PNPP_ACT_CMD, 1'b0, rows[r].cmd);
            last = rows[r].cmd;
            rd_addr <= rows[r].ra;
            byte_select_a <= rows[r].bsa;
            output_enable_n <= 1'b0;
            cyc(6);
            chk(16'(data_oe), 16'h0001);
            chk(16'(data_out), 16'(rows[r].exp));
            output_enable_n <= 1'b1;
            cyc(6);
            chk(16'(data_oe), 16'h0000);
        end
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_NOP);
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_WR_FLASH);
        wr(1'b1, 1'b0);
        eeprom_preserve_fuse <= 1'b0;
        ld(`PNPP_ACT_CMD, 1'b0, `PNPP_CMD_ERASE);
        wr(1'b0, 1'b1);
        rd_addr <= 10'h00B;
        cyc(1);
        chk({lock_bits, eep_rd_data}, 16'hFF5A);
        rd_addr <= 10'h185;
        cyc(1);
        chk(flash_rd_data, 16'hFFFF);
        hv_reset_level <= 1'b0;
        cyc(8);
        chk(16'(prog_mode), 16'h0000);
        resetn <= 1'b0;
        cyc(2);
        chk({lock_bits, fuse_lo}, 16'hFFFF);
        end_sim;
    end
endmodule // pnpp_port_tb_top

bind pnpp_port pnpp_port_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .hv_reset_level(hv_reset_level),
    .output_enable_n(output_enable_n), .eeprom_preserve_fuse(eeprom_preserve_fuse), .data_oe(data_oe),
    .ready_busy_flag(ready_busy_flag), .nvm_req(nvm_req), .nvm_op(nvm_op), .nvm_done(nvm_done),
    .prog_mode(prog_mode), .lock_bits(lock_bits));
